// File: rtl/brp_dev.sv
// backend readout port, device end
// Operation
// - host waits for full count before next
// - burst seven words in fifth 2us slot
// - output fifo holds 4K words
// - new request clears counter and fifo
// - fifo empty gates words to host
// - down-counter decrements per host acknowledge
// - done blocks reads, drivers until request
// - select bit chooses discarded address msb
// - counter runs on, no extra handshakes
// - sixteen tables of 2048 results
// - bank select picks readout buffer bank
// - counter lsb is imag, not ram address
// - form 20-bit buffer address
// - snapshot captures sum on capture strobe
// - write address is delayed bank address
// - output strobe writes snapshot to buffer
// - source drives request, sink drives acknowledge
// - direction low to host, high from host
// - host sends two 12-bit request words
// - latch on request fall, pulse acknowledge
// - send on request fall, await acknowledge fall
// - load ram address, advance after two counts
//
`timescale 1ns/1ps
`include "brp_regs.svh"
module brp_dev #(
    parameter int FIFO_AW = 12,
    parameter int OB_AW   = 20,
    parameter int RR_AW   = 15
) (
    // clock and reset
    input  wire logic               i_clk_sys,
    input  wire logic               i_rst_b,
    input  wire logic               i_clk_en,
    // link to host
    brp_link_if.dev                 lnk,
    // output buffer fill path
    input  wire logic [18:0]        i_accum_addr,
    input  wire brp_pkg::brp_word_t i_fsum,
    input  wire logic               i_snapshot_capture_n,
    input  wire logic               i_snapshot_output_n,
    input  wire logic               i_output_bank_select_n,
    // result ram loading
    input  wire logic               i_rr_addr_load,
    input  wire logic [RR_AW-1:0]   i_rr_addr_init,
    input  wire logic               i_result_addr_increment_en,
    input  wire logic               i_rr_we,
    input  wire logic [11:0]        i_rr_wdata,
    // status
    output logic                    o_done,
    output logic [11:0]             o_result_count
);
    import brp_pkg::*;

    typedef struct packed {
        logic [2:0]                          req_s;
        logic [2:0]                          ack_s;
        logic [1:0]                          dir_s;
        logic [`BRP_CMD_BITS-1:0]            d_s1;
        logic [`BRP_CMD_BITS-1:0]            d_s2;
        logic                                word_sel;
        logic [`BRP_BL_MSB:0]                bl;
        logic [3:0]                          tbl;
        logic [3:0]                          ack_cnt;
        logic                                ack_oe;
        brp_tx_t                             tx;
        logic                                req_oe;
        logic                                d_oe;
        brp_word_t                           d_out;
        logic [11:0]                         remain;
        logic                                done;
        logic [11:0]                         res_cnt;
        logic [5:0]                          slot_cyc;
        logic [2:0]                          slot_idx;
        logic [FIFO_AW:0]                    wp;
        logic [FIFO_AW:0]                    rp;
        brp_word_t                           snap;
        logic [`BRP_SNAP_DLY-1:0][18:0]      dly;
        logic [RR_AW-1:0]                    rr_addr;
        logic                                inc_cnt;
    } brp_dev_st_t;

    brp_dev_st_t st;
    brp_dev_st_t next_st;

    brp_word_t  obuf [0:(1<<OB_AW)-1];
    brp_word_t  fifo [0:(1<<FIFO_AW)-1];
    logic [11:0] rr  [0:(1<<RR_AW)-1];

    logic              req_fall;
    logic              ack_fall;
    logic              empty;
    logic              full;
    logic              push;
    logic              new_req;
    logic [11:0]       rr_ent;
    logic [OB_AW-1:0]  ob_raddr;
    logic [OB_AW-1:0]  ob_waddr;

    // row address drops one msb: baseline's or result's
    function automatic logic [19:0] brp_ob_addr(input logic bank, input logic imag,
                                                input logic [7:0] bl, input logic [11:0] ent);
        logic [17:0] row;
        row = ent[`BRP_RR_SEL] ? {bl, ent[`BRP_RES_MSB-1:0]}
                               : {bl[`BRP_BL_MSB-1:0], ent[`BRP_RES_MSB:0]};
        return {bank, imag, row};
    endfunction : brp_ob_addr

    // decode of link events and buffer state
    assign req_fall = st.req_s[2] & ~st.req_s[1];
    assign ack_fall = st.ack_s[2] & ~st.ack_s[1];
    assign empty    = (st.wp == st.rp);
    assign full     = (st.wp - st.rp) == (FIFO_AW+1)'(1 << FIFO_AW);
    assign new_req  = st.dir_s[1] & req_fall & st.word_sel;
    // one entry serves both halves, so the lsb stays off the ram
    assign rr_ent   = rr[{st.tbl, st.res_cnt[11:1]}];
    assign ob_raddr = brp_ob_addr(i_output_bank_select_n, st.res_cnt[0], st.bl, rr_ent);
    assign ob_waddr = {~i_output_bank_select_n, st.dly[`BRP_SNAP_DLY-1]};
    // burst only in the slot where the address bus is idle
    assign push     = (st.slot_idx == 3'(`BRP_BURST_SLOT))
                    && (st.slot_cyc < 6'(`BRP_BURST_LEN)) && !full && !new_req;

    always_comb
    begin
        next_st = st;
        // synchronisers for the link pins
        next_st.req_s = {st.req_s[1:0], lnk.req_n};
        next_st.ack_s = {st.ack_s[1:0], lnk.ack_n};
        next_st.dir_s = {st.dir_s[0], lnk.transfer_direction};
        next_st.d_s1  = lnk.d[`BRP_CMD_BITS-1:0];
        next_st.d_s2  = st.d_s1;
        // acknowledge pulse length
        if (st.ack_cnt != 4'h0)
        begin
            next_st.ack_cnt = st.ack_cnt - 4'h1;
            if (st.ack_cnt == 4'h1)
                next_st.ack_oe = 1'b0;
        end
        // 2us slot timer, five slots per 10us cycle
        if (st.slot_cyc == 6'(`BRP_SLOT_CYC - 1))
        begin
            next_st.slot_cyc = 6'h00;
            next_st.slot_idx = (st.slot_idx == 3'(`BRP_SLOTS - 1)) ? 3'h0 : st.slot_idx + 3'h1;
        end
        else
            next_st.slot_cyc = st.slot_cyc + 6'h01;
        // buffer to fifo; counter keeps running past the request
        if (push)
        begin
            next_st.wp      = st.wp + 1'b1;
            next_st.res_cnt = st.res_cnt + 12'h001;
        end
        // snapshot register and delayed bank address
        if (!i_snapshot_capture_n)
            next_st.snap = i_fsum;
        next_st.dly = {st.dly[`BRP_SNAP_DLY-2:0], i_accum_addr};
        // result ram address: load, then step after two enabled counts
        if (i_rr_addr_load)
        begin
            next_st.rr_addr = i_rr_addr_init;
            next_st.inc_cnt = 1'b0;
        end
        else if (i_result_addr_increment_en)
        begin
            if (st.inc_cnt == 1'(`BRP_INC_HOLD - 1))
            begin
                next_st.rr_addr = st.rr_addr + 1'b1;
                next_st.inc_cnt = 1'b0;
            end
            else
                next_st.inc_cnt = st.inc_cnt + 1'b1;
        end
        else
            next_st.inc_cnt = 1'b0;
        // words from host while direction is high
        if (st.dir_s[1] && req_fall)
        begin
            next_st.ack_oe  = 1'b1;
            next_st.ack_cnt = 4'(`BRP_ACK_CYC);
            next_st.word_sel = ~st.word_sel;
            if (!st.word_sel)
            begin
                next_st.bl  = st.d_s2[`BRP_BL_MSB:0];
                next_st.tbl = st.d_s2[`BRP_IDX_MSB:`BRP_IDX_LSB];
            end
            else
            begin
                // second word starts the baseline from result zero
                next_st.remain  = st.d_s2;
                next_st.done    = (st.d_s2 == 12'h000);
                next_st.res_cnt = 12'h000;
                next_st.wp      = '0;
                next_st.rp      = '0;
            end
        end
        // words to host
        unique case (st.tx)
            BRP_TX_IDLE:
            begin
                if (!st.dir_s[1] && !st.done && st.remain != 12'h000 && !empty)
                begin
                    next_st.d_out = fifo[st.rp[FIFO_AW-1:0]];
                    next_st.d_oe  = 1'b1;
                    next_st.tx    = BRP_TX_SETUP;
                end
            end
            BRP_TX_SETUP:
            begin
                next_st.req_oe = 1'b1;
                next_st.tx     = BRP_TX_REQ;
            end
            BRP_TX_REQ:
            begin
                if (ack_fall)
                begin
                    next_st.req_oe = 1'b0;
                    next_st.d_oe   = 1'b0;
                    next_st.rp     = st.rp + 1'b1;
                    next_st.remain = st.remain - 12'h001;
                    if (st.remain == 12'h001)
                        next_st.done = 1'b1;
                    next_st.tx = BRP_TX_GAP;
                end
            end
            BRP_TX_GAP:
            begin
                if (st.ack_s[1])
                    next_st.tx = BRP_TX_IDLE;
            end
        endcase
        // host turned the bus round: let go at once
        if (st.dir_s[1] && st.tx != BRP_TX_IDLE)
        begin
            next_st.req_oe = 1'b0;
            next_st.d_oe   = 1'b0;
            next_st.tx     = BRP_TX_IDLE;
        end
    end

    // state register
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            st    <= '0;
            st.tx <= BRP_TX_IDLE;
        end
        else if (i_clk_en)
            st <= next_st;
    end

    // memories: buffer, fifo and result ram
    always_ff @(posedge i_clk_sys)
    begin
        if (i_clk_en)
        begin
            if (!i_snapshot_output_n)
                obuf[ob_waddr] <= st.snap;
            if (push)
                fifo[st.wp[FIFO_AW-1:0]] <= obuf[ob_raddr];
            if (i_rr_we)
                rr[st.rr_addr] <= i_rr_wdata;
        end
    end

    // outputs from the state register
    assign lnk.dev_d      = st.d_out;
    assign lnk.dev_d_oe   = st.d_oe;
    assign lnk.dev_req_oe = st.req_oe;
    assign lnk.dev_ack_oe = st.ack_oe;
    assign o_done         = st.done;
    assign o_result_count = st.res_cnt;
endmodule : brp_dev

// File: rtl/brp_host.sv
// backend readout port, host end
`timescale 1ns/1ps
`include "brp_regs.svh"
module brp_host (
    // clock and reset
    input  wire logic               i_clk_sys,
    input  wire logic               i_rst_b,
    input  wire logic               i_clk_en,
    // link to device
    brp_link_if.host                lnk,
    // request side
    input  wire logic               i_start,
    input  wire logic [7:0]         i_baseline,
    input  wire logic [3:0]         i_table_index,
    input  wire logic [11:0]        i_count,
    // answer side
    output logic                    o_busy,
    output logic                    o_rx_valid,
    output brp_pkg::brp_word_t      o_rx_data
);
    import brp_pkg::*;

    typedef struct packed {
        brp_host_st_t fsm;
        logic [2:0]   req_s;
        logic [2:0]   ack_s;
        brp_word_t    d_s1;
        brp_word_t    d_s2;
        logic         word_sel;
        logic [11:0]  cnt;
        logic [11:0]  remain;
        brp_word_t    d_out;
        logic         d_oe;
        logic         req_oe;
        logic         ack_oe;
        logic [3:0]   ack_cnt;
        logic         dir;
        logic         busy;
        logic         rx_valid;
        brp_word_t    rx_data;
    } brp_host_t;

    brp_host_t st;
    brp_host_t next_st;

    logic req_fall;
    logic ack_fall;

    assign req_fall = st.req_s[2] & ~st.req_s[1];
    assign ack_fall = st.ack_s[2] & ~st.ack_s[1];

    always_comb
    begin
        next_st = st;
        next_st.req_s    = {st.req_s[1:0], lnk.req_n};
        next_st.ack_s    = {st.ack_s[1:0], lnk.ack_n};
        next_st.d_s1     = lnk.d;
        next_st.d_s2     = st.d_s1;
        next_st.rx_valid = 1'b0;
        // acknowledge pulse length
        if (st.ack_cnt != 4'h0)
        begin
            next_st.ack_cnt = st.ack_cnt - 4'h1;
            if (st.ack_cnt == 4'h1)
                next_st.ack_oe = 1'b0;
        end
        unique case (st.fsm)
            BRP_H_IDLE:
            begin
                // busy holds until our ack ends and the device lets go of request
                if (st.busy)
                    next_st.busy = st.ack_oe | ~st.req_s[1];
                // start refused while a baseline is still owed
                else if (i_start)
                begin
                    next_st.busy     = 1'b1;
                    next_st.dir      = 1'b1;
                    next_st.d_out    = {20'h00000, i_table_index, i_baseline};
                    next_st.d_oe     = 1'b1;
                    next_st.cnt      = i_count;
                    next_st.remain   = i_count;
                    next_st.word_sel = 1'b0;
                    next_st.fsm      = BRP_H_SETUP;
                end
            end
            BRP_H_SETUP:
            begin
                next_st.req_oe = 1'b1;
                next_st.fsm    = BRP_H_REQ;
            end
            BRP_H_REQ:
            begin
                if (ack_fall)
                begin
                    next_st.req_oe = 1'b0;
                    next_st.fsm    = BRP_H_REL;
                end
            end
            BRP_H_REL:
            begin
                if (st.ack_s[1] && !st.word_sel)
                begin
                    next_st.word_sel = 1'b1;
                    next_st.d_out    = {20'h00000, st.cnt};
                    next_st.fsm      = BRP_H_SETUP;
                end
                else if (st.ack_s[1])
                begin
                    next_st.d_oe = 1'b0;
                    next_st.dir  = 1'b0;
                    next_st.busy = (st.cnt != 12'h000);
                    next_st.fsm  = (st.cnt != 12'h000) ? BRP_H_RECV : BRP_H_IDLE;
                end
            end
            BRP_H_RECV:
            begin
                if (req_fall)
                begin
                    next_st.rx_data  = st.d_s2;
                    next_st.rx_valid = 1'b1;
                    next_st.ack_oe   = 1'b1;
                    next_st.ack_cnt  = 4'(`BRP_ACK_CYC);
                    next_st.remain   = st.remain - 12'h001;
                    if (st.remain == 12'h001)
                        next_st.fsm = BRP_H_IDLE; // busy drops once the line is idle
                end
            end
        endcase
    end

    // state register
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            st     <= '0;
            st.fsm <= BRP_H_IDLE;
        end
        else if (i_clk_en)
            st <= next_st;
    end

    // outputs from the state register
    assign lnk.host_d             = st.d_out;
    assign lnk.host_d_oe          = st.d_oe;
    assign lnk.host_req_oe        = st.req_oe;
    assign lnk.host_ack_oe        = st.ack_oe;
    assign lnk.transfer_direction = st.dir;
    assign o_busy                 = st.busy;
    assign o_rx_valid             = st.rx_valid;
    assign o_rx_data              = st.rx_data;
endmodule : brp_host

// File: rtl/brp_link_if.sv
// parallel link between readout device and host
`timescale 1ns/1ps
interface brp_link_if;
    logic [31:0] dev_d;
    logic [31:0] host_d;
    logic        dev_d_oe;
    logic        host_d_oe;
    logic        dev_req_oe;
    logic        host_req_oe;
    logic        dev_ack_oe;
    logic        host_ack_oe;
    logic        transfer_direction;
    logic [31:0] d;
    logic        req_n;
    logic        ack_n;
    // bus idles high; open-collector lines are low while either side pulls
    assign d     = dev_d_oe ? dev_d : (host_d_oe ? host_d : 32'hFFFFFFFF);
    assign req_n = ~(dev_req_oe | host_req_oe);
    assign ack_n = ~(dev_ack_oe | host_ack_oe);
    modport dev  (output dev_d, dev_d_oe, dev_req_oe, dev_ack_oe,
                  input d, req_n, ack_n, transfer_direction);
    modport host (output host_d, host_d_oe, host_req_oe, host_ack_oe, transfer_direction,
                  input d, req_n, ack_n);
endinterface : brp_link_if

// File: rtl/brp_pkg.sv
// types shared by both ends of the backend readout port
package brp_pkg;
    typedef logic [31:0] brp_word_t;
    typedef enum logic [3:0] {
        BRP_TX_IDLE  = 4'h1,
        BRP_TX_SETUP = 4'h2,
        BRP_TX_REQ   = 4'h4,
        BRP_TX_GAP   = 4'h8
    } brp_tx_t;
    typedef enum logic [4:0] {
        BRP_H_IDLE  = 5'h01,
        BRP_H_SETUP = 5'h02,
        BRP_H_REQ   = 5'h04,
        BRP_H_REL   = 5'h08,
        BRP_H_RECV  = 5'h10
    } brp_host_st_t;
endpackage : brp_pkg

// File: rtl/brp_regs.svh
// constants of the backend readout port
`ifndef BRP_REGS_SVH
`define BRP_REGS_SVH
`define BRP_CLK_NS 40
`define BRP_SLOT_NS 2000
`define BRP_CYCLE_NS 10000
`define BRP_SLOT_CYC (`BRP_SLOT_NS / `BRP_CLK_NS)
`define BRP_SLOTS (`BRP_CYCLE_NS / `BRP_SLOT_NS)
`define BRP_BURST_SLOT 4
`define BRP_BURST_LEN 7
`define BRP_SNAP_DLY 7
`define BRP_ACK_CYC 4
`define BRP_INC_HOLD 2
`define BRP_CMD_BITS 12
`define BRP_BL_MSB 7
`define BRP_IDX_LSB 8
`define BRP_IDX_MSB 11
`define BRP_RR_SEL 11
`define BRP_RES_MSB 10
`endif

// File: testbench/backend_readout_port_bench.sv
// self-checking bench joining device and host ends
`timescale 1ns/1ps
module backend_readout_port_bench;
    import brp_pkg::*;
    logic             clk = 1'b0;
    logic             rst_b = 1'b0;
    logic [18:0]      accum_addr = '0;
    brp_word_t        fsum = '0;
    logic             cap_n = 1'b1;
    logic             out_n = 1'b1;
    logic             bank_n = 1'b1;
    logic             rr_load = 1'b0;
    logic [14:0]      rr_init = '0;
    logic             rr_inc = 1'b0;
    logic             rr_we = 1'b0;
    logic [11:0]      rr_wdata = '0;
    logic             start = 1'b0;
    logic [7:0]       bl = '0;
    logic [3:0]       tidx = '0;
    logic [11:0]      cnt = '0;
    logic             done;
    logic [11:0]      rcount;
    logic             busy;
    logic             rx_valid;
    brp_word_t        rx_data;
    int               num_errors = 0;
    int               checks_done = 0;

    brp_link_if lnk ();
    brp_dev i_brp_dev (.i_clk_sys(clk), .i_rst_b(rst_b), .i_clk_en(1'b1), .lnk(lnk),
        .i_accum_addr(accum_addr), .i_fsum(fsum), .i_snapshot_capture_n(cap_n),
        .i_snapshot_output_n(out_n), .i_output_bank_select_n(bank_n),
        .i_rr_addr_load(rr_load), .i_rr_addr_init(rr_init),
        .i_result_addr_increment_en(rr_inc), .i_rr_we(rr_we), .i_rr_wdata(rr_wdata),
        .o_done(done), .o_result_count(rcount));
    brp_host i_brp_host (.i_clk_sys(clk), .i_rst_b(rst_b), .i_clk_en(1'b1), .lnk(lnk),
        .i_start(start), .i_baseline(bl), .i_table_index(tidx), .i_count(cnt),
        .o_busy(busy), .o_rx_valid(rx_valid), .o_rx_data(rx_data));
    brp_link_assertions i_brp_link_assertions (.i_clk_sys(clk), .i_rst_b(rst_b),
        .dev_d(lnk.dev_d), .dev_d_oe(lnk.dev_d_oe), .dev_req_oe(lnk.dev_req_oe),
        .dev_ack_oe(lnk.dev_ack_oe), .host_req_oe(lnk.host_req_oe),
        .transfer_direction(lnk.transfer_direction), .req_n(lnk.req_n), .ack_n(lnk.ack_n));

    // 25 MHz system clock
    always #20 clk = ~clk;

    task automatic complete_run();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run

    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_word

    task automatic chk_bit(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit

    // row address as the select bit decides
    function automatic logic [17:0] f_row(input logic s, input logic [7:0] b,
                                          input logic [10:0] r);
        return s ? {b, r[9:0]} : {b[6:0], r};
    endfunction : f_row

    // host request, then collect and judge the answer words
    task automatic t_request(input logic [7:0] b, input logic [3:0] t, input logic [11:0] n,
                             input brp_word_t exp[$]);
        int got;
        int waitc;
        got = 0;
        waitc = 0;
        while (busy !== 1'b0 && waitc < 2000)
        begin
            @(negedge clk);
            waitc++;
        end
        @(posedge clk);
        start <= 1'b1;
        bl <= b;
        tidx <= t;
        cnt <= n;
        @(posedge clk);
        start <= 1'b0;
        for (int c = 0; c < 6000 && got < n; c++)
        begin
            @(negedge clk);
            if (rx_valid === 1'b1)
            begin
                chk_word("rx_word", exp[got], rx_data);
                got++;
            end
        end
        chk_word("words_seen", 32'(n), 32'(got));
        repeat (20) @(negedge clk);
        chk_bit("done_set", 1'b1, done);
        // no more handshakes although the counter runs on
        for (int c = 0; c < 600; c++)
        begin
            @(negedge clk);
            if (rx_valid === 1'b1 || lnk.dev_d_oe !== 1'b0)
                chk_bit("quiet_after_done", 1'b0, 1'b1);
        end
        chk_bit("done_held", 1'b1, done);
        chk_bit("count_runs_on", 1'b1, rcount > n);
        chk_bit("busy_clear", 1'b0, busy);
    endtask : t_request

    // load a table, fill the buffer, swap banks and read back
    task automatic t_run(input logic [7:0] b, input logic [3:0] t, input logic s,
                         input logic bk_n, input int n);
        brp_word_t exp[$];
        logic [10:0] r;
        logic [18:0] a;
        exp = {};
        @(posedge clk);
        rr_load <= 1'b1;
        rr_init <= {t, 11'h000};
        @(posedge clk);
        rr_load <= 1'b0;
        bank_n <= bk_n;
        for (int e = 0; e < (n + 1) / 2; e++)
        begin
            @(posedge clk);
            rr_we <= 1'b1;
            rr_wdata <= {s, 11'(e * 5 + t + 1)};
            @(posedge clk);
            rr_we <= 1'b0;
            rr_inc <= 1'b1;
            @(posedge clk);
            @(posedge clk);
            rr_inc <= 1'b0;
        end
        // snapshot each word into the write bank
        for (int k = 0; k < n; k++)
        begin
            r = 11'((k / 2) * 5 + t + 1);
            a = {k[0], f_row(s, b, r)};
            exp.push_back({12'hA50, 1'b0, a});
            @(posedge clk);
            accum_addr <= a;
            fsum <= {12'hA50, 1'b0, a};
            repeat (8) @(posedge clk);
            cap_n <= 1'b0;
            @(posedge clk);
            cap_n <= 1'b1;
            out_n <= 1'b0;
            @(posedge clk);
            out_n <= 1'b1;
        end
        @(posedge clk);
        bank_n <= ~bk_n;
        t_request(b, t, 12'(n), exp);
    endtask : t_run

    task automatic t_reset_check();
        chk_bit("done_rst", 1'b0, done);
        chk_word("count_rst", 32'h0, 32'(rcount));
        chk_bit("req_rst", 1'b1, lnk.req_n);
        chk_bit("ack_rst", 1'b1, lnk.ack_n);
        chk_bit("dir_rst", 1'b0, lnk.transfer_direction);
    endtask : t_reset_check

    // reset in mid-run: nothing may be sent before a baseline is asked for
    task automatic t_reset_quiet();
        int seen;
        seen = 0;
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        t_reset_check();
        repeat (600)
        begin
            @(negedge clk);
            if (lnk.dev_req_oe !== 1'b0 || lnk.dev_d_oe !== 1'b0)
                seen++;
        end
        chk_word("quiet_before_request", 32'h0, 32'(seen));
    endtask : t_reset_quiet

    // count of zero completes at once and silences the link
    task automatic t_zero_count();
        brp_word_t none[$];
        none = {};
        t_request(8'h00, 4'h0, 12'h000, none);
    endtask : t_zero_count

    // watchdog sized well beyond the scenarios
    initial
    begin
        #(40 * 60000);
        num_errors++;
        complete_run();
    end

    initial
    begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        t_reset_check();
        t_zero_count();
        t_run(8'h25, 4'h3, 1'b1, 1'b1, 6);
        t_run(8'h4A, 4'hF, 1'b0, 1'b0, 9);
        t_reset_quiet();
        complete_run();
    end
endmodule : backend_readout_port_bench

// File: testbench/brp_link_assertions.sv
// link protocol checks between readout device and host
`timescale 1ns/1ps
module brp_link_assertions (
    // clock and reset
    input wire logic        i_clk_sys,
    input wire logic        i_rst_b,
    // link signals
    input wire logic [31:0] dev_d,
    input wire logic        dev_d_oe,
    input wire logic        dev_req_oe,
    input wire logic        dev_ack_oe,
    input wire logic        host_req_oe,
    input wire logic        transfer_direction,
    input wire logic        req_n,
    input wire logic        ack_n
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);

    // device sources words only toward the host
    property p_dev_req_dir; dev_req_oe |-> !transfer_direction; endproperty
    a_dev_req_dir: assert property (p_dev_req_dir) else $error("device request with dir high");
    // host sources words only toward the device
    property p_host_req_dir; host_req_oe |-> transfer_direction; endproperty
    a_host_req_dir: assert property (p_host_req_dir) else $error("host request with dir low");
    // device acknowledges only while receiving
    property p_ack_dir; $rose(dev_ack_oe) |-> transfer_direction; endproperty
    a_ack_dir: assert property (p_ack_dir) else $error("device ack with dir low");
    // ack is a fixed pulse of four cycles
    property p_ack_pulse; $rose(dev_ack_oe) |-> dev_ack_oe [*4] ##1 !dev_ack_oe; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack pulse length wrong");
    // every host request fall is answered
    property p_ack_answer; $fell(req_n) && host_req_oe |-> ##[1:6] $rose(dev_ack_oe); endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("host word not acknowledged");
    // request never without data on the bus
    property p_req_data; dev_req_oe |-> dev_d_oe; endproperty
    a_req_data: assert property (p_req_data) else $error("request without data");
    // request held until the acknowledge falls
    property p_req_hold; dev_req_oe && ack_n |=> dev_req_oe; endproperty
    a_req_hold: assert property (p_req_hold) else $error("request dropped before ack");
    // word stays put while presented
    property p_data_stable; dev_req_oe && $past(dev_req_oe) |-> $stable(dev_d); endproperty
    a_data_stable: assert property (p_data_stable) else $error("word changed during request");

    c_dev_word: cover property ($rose(dev_req_oe));
    c_host_word: cover property ($rose(host_req_oe));
    c_dir_back: cover property ($fell(transfer_direction));
endmodule : brp_link_assertions
